/* src/fic_pkg.sv */
package fic_pkg;

    // ==========================================================
    // sizes and vectors
    localparam int          NUM_SRC  = 14;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_LAST = 16'h006b;
    // pins are active low, so their idle level is all ones
    localparam logic [2:0]  PIN_IDLE = 3'h7;

    // ==========================================================
    // source numbers, polling order (0 wins ties)
    localparam logic [3:0] SRC_EXT0    = 4'h0;
    localparam logic [3:0] SRC_TIMER_A = 4'h1;
    localparam logic [3:0] SRC_EXT1    = 4'h2;
    localparam logic [3:0] SRC_TIMER_B = 4'h3;
    localparam logic [3:0] SRC_UART    = 4'h4;
    localparam logic [3:0] SRC_TIMER_C = 4'h5;
    localparam logic [3:0] SRC_EXT2    = 4'h6;
    localparam logic [3:0] SRC_SPI     = 4'h7;
    localparam logic [3:0] SRC_CONV    = 4'h8;
    localparam logic [3:0] SRC_ARRAY   = 4'h9;
    localparam logic [3:0] SRC_SYSFLAG = 4'ha;
    localparam logic [3:0] SRC_KEYPAD  = 4'hb;
    localparam logic [3:0] SRC_TWOWIRE = 4'hc;
    localparam logic [3:0] SRC_COMP    = 4'hd;

    // ==========================================================
    // register byte offsets
    localparam logic [11:0] OFF_ENABLE      = 12'h000;
    localparam logic [11:0] OFF_PRIO_LOW_A  = 12'h004;
    localparam logic [11:0] OFF_PRIO_HIGH_A = 12'h008;
    localparam logic [11:0] OFF_PRIO_LOW_B  = 12'h00c;
    localparam logic [11:0] OFF_PRIO_HIGH_B = 12'h010;
    localparam logic [11:0] OFF_TIMER_CTRL  = 12'h014;
    localparam logic [11:0] OFF_EXT_CTRL    = 12'h018;
    localparam logic [11:0] OFF_PERIPH_FLAG = 12'h01c;
    localparam logic [11:0] OFF_POWER_CTRL  = 12'h020;
    localparam logic [11:0] OFF_AUX_C       = 12'h024;
    localparam logic [11:0] OFF_STATUS      = 12'h028;

    // ==========================================================
    // field positions
    localparam int EN_GLOBAL   = 31;
    localparam int TC_EXT0_TYP = 0;
    localparam int TC_EXT0_FLG = 1;
    localparam int TC_EXT1_TYP = 2;
    localparam int TC_EXT1_FLG = 3;
    localparam int TC_TMR_A    = 5;
    localparam int TC_TMR_B    = 7;
    localparam int XC_EXT2_TYP = 0;
    localparam int XC_EXT2_FLG = 1;
    localparam int PF_URX      = 0;
    localparam int PF_UTX      = 1;
    localparam int PF_TC_OVF   = 2;
    localparam int PF_TC_EXT   = 3;
    localparam int PF_SPI      = 4;
    localparam int PF_CONV     = 5;
    localparam int PF_KEYPAD   = 6;
    localparam int PF_TWOWIRE  = 7;
    localparam int PF_COMP     = 8;
    localparam int PF_ARR_OVF  = 9;
    localparam int PF_ARR_MOD  = 10;
    localparam int PC_WDT      = 0;
    localparam int PC_BO_B     = 1;
    localparam int PC_BO_A     = 2;
    localparam int PC_CAL      = 4;
    localparam int PC_MCLK     = 5;
    localparam int AX_UTX_SYS  = 0;
    localparam int AX_STOP     = 6;
    localparam int AX_START    = 7;

    // writable bits; everything else reads zero
    localparam logic [7:0] TC_MASK = 8'hbf;
    localparam logic [7:0] XC_MASK = 8'h03;
    localparam logic [7:0] PC_MASK = 8'h37;
    localparam logic [7:0] AX_MASK = 8'hc1;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       timer_a_rollover;
        logic       timer_b_rollover;
        logic       uart_rx_done;
        logic       uart_tx_done;
        logic       timer_c_overflow;
        logic       timer_c_external;
        logic       spi_transfer_done;
        logic       converter_done;
        logic       keypad_match;
        logic       twowire_new_state;
        logic       comparator_change;
        logic       array_counter_overflow;
        logic [5:0] array_module_match;
        logic       watchdog_overflow;
        logic       brownout_a;
        logic       brownout_b;
        logic       calendar_overflow;
        logic       missing_clock;
        logic       serial_start_detect;
        logic       serial_stop_detect;
    } fic_evt_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] level;
        logic [3:0] idx;
    } fic_arb_t;

    typedef struct packed {
        logic [13:0] ena;
        logic        ea;
        logic [6:0]  pl_a;
        logic [6:0]  ph_a;
        logic [6:0]  pl_b;
        logic [6:0]  ph_b;
        logic [7:0]  timer_control_reg;
        logic [7:0]  xcon;
        logic [15:0] pflag;
        logic [7:0]  pcon;
        logic [7:0]  aux;
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [2:0]  prev;
        logic [13:0] sample;
        logic [3:0]  in_srv;
        logic        hold;
        logic        vec_valid;
        logic [15:0] vec_addr;
        logic [1:0]  vec_level;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } fic_state_t;

endpackage

/* src/fic_intc.sv */
`timescale 1ns/1ps
// Functional notes
// - fourteen sources arbitrated over four priority levels.
// - a flag interrupts only with its enable and the global enable set.
// - source n vectors to 0x0003 plus 8 times n, last at 0x006b.
// - ties within one level go to the lowest source number.
// - software may write every request flag to one or zero, except level-mode external flags, which follow their pins.
// - each external input is level or edge sensitive by its type bit.
// - edge flags clear on vectoring; level flags follow the input.
// - external 0/1 flags in timer control, external 2 in extra control.
// - timer a/b flags set on rollover, cleared on vectoring.
// - uart request is rx-done or tx-done; never cleared on vectoring.
// - timer c request is overflow or external flag; not cleared on vectoring.
// - spi done flag stays set until software clears it.
// - converter done flag is not cleared on vectoring.
// - array request is counter overflow or any of six module flags.
// - system request ORs clock, calendar, brownout, watchdog, start, stop flags.
// - power register bits 0,1,2,4,5; auxiliary bits 7 and 6.
// - with its option set, uart tx-done also raises the system request.
// - keypad match flag stays set until software clears it.
// - two-wire new-state flag is not cleared on vectoring.
// - comparator change flag is not cleared on vectoring.
// - each source has a low and a high priority bit.
// - high,low bits 11 highest, 10, 01, 00 lowest.
// - no preemption by lower level; higher level wins simultaneous requests.
// - flags sampled each clock, polled the next, then vector call.
// - block on equal/higher in service, non-final cycle, reti or config write.
module fic_intc (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // external interrupt pins, active low
    input  wire logic             ext_irq_pin_a,
    input  wire logic             ext_irq_pin_b,
    input  wire logic             ext_irq_pin_c,
    // peripheral flag set pulses
    input  wire fic_pkg::fic_evt_t evt,
    // cpu core
    input  wire logic             core_final_cycle,
    input  wire logic             core_reti,
    output logic                  vec_valid,
    output logic [15:0]           vec_addr,
    output logic [1:0]            vec_level
);

    // ==========================================================
    // helpers
    function automatic logic [7:0] upd8(input logic [7:0] q, input logic we,
                                        input logic [7:0] m, input logic [7:0] w,
                                        input logic [7:0] set, input logic [7:0] clr);
        logic [7:0] v;
        v = we ? ((q & ~m) | (w & m)) : q;
        // hardware set wins over any clear in the same cycle
        return (v & ~clr) | set;
    endfunction

    function automatic logic [15:0] upd16(input logic [15:0] q, input logic we,
                                          input logic [15:0] m, input logic [15:0] w,
                                          input logic [15:0] set);
        logic [15:0] v;
        v = we ? ((q & ~m) | (w & m)) : q;
        return v | set;
    endfunction

    function automatic fic_pkg::fic_arb_t arbitrate(input logic [13:0] req,
                                                    input logic [13:0] hi,
                                                    input logic [13:0] lo);
        fic_pkg::fic_arb_t r;
        r = '0;
        // walk downward so an equal level at a lower number takes over
        for (int i = fic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req[i] && (!r.valid || {hi[i], lo[i]} >= r.level)) begin
                r.valid = 1'b1;
                r.level = {hi[i], lo[i]};
                r.idx   = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] top_level(input logic [3:0] srv);
        logic [2:0] t;
        t = 3'h0;
        for (int l = 0; l < 4; l++) begin
            if (srv[l]) begin
                t = {1'b1, 2'(l)};
            end
        end
        return t;
    endfunction

    // ==========================================================
    // state
    fic_pkg::fic_state_t q, d;
    fic_pkg::fic_arb_t   arb;
    logic [13:0]         req, hi14, lo14;
    logic [2:0]          top, act, fall;
    logic                take, wr, rd_phase, cfg_wr;
    logic [31:0]         m;

    always_comb begin
        d = q;
        m = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        wr       = psel & penable & q.pready & pwrite;
        rd_phase = psel & penable & ~q.pready;
        cfg_wr   = wr & (paddr == fic_pkg::OFF_ENABLE || paddr == fic_pkg::OFF_PRIO_LOW_A
                      || paddr == fic_pkg::OFF_PRIO_HIGH_A || paddr == fic_pkg::OFF_PRIO_LOW_B
                      || paddr == fic_pkg::OFF_PRIO_HIGH_B || paddr == fic_pkg::OFF_EXT_CTRL);

        // pin synchronisers; pins are active low
        d.sync1 = {ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a};
        d.sync2 = q.sync1;
        d.prev  = q.sync2;
        act     = ~q.sync2;
        fall    = q.prev & ~q.sync2;

        // request lines per source
        req = '0;
        req[fic_pkg::SRC_EXT0]    = q.timer_control_reg[fic_pkg::TC_EXT0_FLG];
        req[fic_pkg::SRC_TIMER_A] = q.timer_control_reg[fic_pkg::TC_TMR_A];
        req[fic_pkg::SRC_EXT1]    = q.timer_control_reg[fic_pkg::TC_EXT1_FLG];
        req[fic_pkg::SRC_TIMER_B] = q.timer_control_reg[fic_pkg::TC_TMR_B];
        req[fic_pkg::SRC_UART]    = q.pflag[fic_pkg::PF_URX] | q.pflag[fic_pkg::PF_UTX];
        req[fic_pkg::SRC_TIMER_C] = q.pflag[fic_pkg::PF_TC_OVF]
                                  | q.pflag[fic_pkg::PF_TC_EXT];
        req[fic_pkg::SRC_EXT2]    = q.xcon[fic_pkg::XC_EXT2_FLG];
        req[fic_pkg::SRC_SPI]     = q.pflag[fic_pkg::PF_SPI];
        req[fic_pkg::SRC_CONV]    = q.pflag[fic_pkg::PF_CONV];
        req[fic_pkg::SRC_ARRAY]   = q.pflag[fic_pkg::PF_ARR_OVF]
                                  | (|q.pflag[15:fic_pkg::PF_ARR_MOD]);
        req[fic_pkg::SRC_SYSFLAG] = (|(q.pcon & fic_pkg::PC_MASK))
                                  | q.aux[fic_pkg::AX_START] | q.aux[fic_pkg::AX_STOP]
                                  | (q.aux[fic_pkg::AX_UTX_SYS] & q.pflag[fic_pkg::PF_UTX]);
        req[fic_pkg::SRC_KEYPAD]  = q.pflag[fic_pkg::PF_KEYPAD];
        req[fic_pkg::SRC_TWOWIRE] = q.pflag[fic_pkg::PF_TWOWIRE];
        req[fic_pkg::SRC_COMP]    = q.pflag[fic_pkg::PF_COMP];

        // sample now, poll next clock
        d.sample = req & q.ena & {14{q.ea}};
        hi14 = {q.ph_b, q.ph_a};
        lo14 = {q.pl_b, q.pl_a};
        arb  = arbitrate(q.sample, hi14, lo14);
        top  = top_level(q.in_srv);
        take = arb.valid & core_final_cycle & ~q.hold & ~core_reti & ~cfg_wr
             & (!top[2] || arb.level > top[1:0]);

        d.vec_valid = take;
        if (take) begin
            d.vec_addr  = fic_pkg::VEC_BASE + {9'h000, arb.idx, 3'h0};
            d.vec_level = arb.level;
        end
        if (core_reti && top[2]) begin
            d.in_srv[top[1:0]] = 1'b0;
        end
        if (take) begin
            d.in_srv[arb.level] = 1'b1;
        end
        // one instruction of grace after reti or a config write
        d.hold = (q.hold & ~core_final_cycle) | core_reti | cfg_wr;

        // ======================================================
        // flag registers
        begin : flags
            logic [7:0] tset, tclr, xset, xclr, pset, aset;
            logic [15:0] fset;
            tset = '0;
            tclr = '0;
            xset = '0;
            xclr = '0;
            fset = {evt.array_module_match, evt.array_counter_overflow,
                    evt.comparator_change, evt.twowire_new_state, evt.keypad_match,
                    evt.converter_done, evt.spi_transfer_done, evt.timer_c_external,
                    evt.timer_c_overflow, evt.uart_tx_done, evt.uart_rx_done};
            pset = {2'b00, evt.missing_clock, evt.calendar_overflow, 1'b0,
                    evt.brownout_a, evt.brownout_b, evt.watchdog_overflow};
            aset = {evt.serial_start_detect, evt.serial_stop_detect, 6'h00};
            if (q.timer_control_reg[fic_pkg::TC_EXT0_TYP]) begin
                tset[fic_pkg::TC_EXT0_FLG] = fall[0];
                tclr[fic_pkg::TC_EXT0_FLG] = take && arb.idx == fic_pkg::SRC_EXT0;
            end else begin
                tset[fic_pkg::TC_EXT0_FLG] = act[0];
                tclr[fic_pkg::TC_EXT0_FLG] = ~act[0];
            end
            if (q.timer_control_reg[fic_pkg::TC_EXT1_TYP]) begin
                tset[fic_pkg::TC_EXT1_FLG] = fall[1];
                tclr[fic_pkg::TC_EXT1_FLG] = take && arb.idx == fic_pkg::SRC_EXT1;
            end else begin
                tset[fic_pkg::TC_EXT1_FLG] = act[1];
                tclr[fic_pkg::TC_EXT1_FLG] = ~act[1];
            end
            if (q.xcon[fic_pkg::XC_EXT2_TYP]) begin
                xset[fic_pkg::XC_EXT2_FLG] = fall[2];
                xclr[fic_pkg::XC_EXT2_FLG] = take && arb.idx == fic_pkg::SRC_EXT2;
            end else begin
                xset[fic_pkg::XC_EXT2_FLG] = act[2];
                xclr[fic_pkg::XC_EXT2_FLG] = ~act[2];
            end
            tset[fic_pkg::TC_TMR_A] = evt.timer_a_rollover;
            tset[fic_pkg::TC_TMR_B] = evt.timer_b_rollover;
            tclr[fic_pkg::TC_TMR_A] = take && arb.idx == fic_pkg::SRC_TIMER_A;
            tclr[fic_pkg::TC_TMR_B] = take && arb.idx == fic_pkg::SRC_TIMER_B;
            // software writes act like hardware updates
            d.timer_control_reg  = upd8(q.timer_control_reg, wr && paddr == fic_pkg::OFF_TIMER_CTRL,
                           m[7:0] & fic_pkg::TC_MASK, pwdata[7:0], tset, tclr);
            d.xcon  = upd8(q.xcon, wr && paddr == fic_pkg::OFF_EXT_CTRL,
                           m[7:0] & fic_pkg::XC_MASK, pwdata[7:0], xset, xclr);
            d.pcon  = upd8(q.pcon, wr && paddr == fic_pkg::OFF_POWER_CTRL,
                           m[7:0] & fic_pkg::PC_MASK, pwdata[7:0], pset, 8'h00);
            d.aux   = upd8(q.aux, wr && paddr == fic_pkg::OFF_AUX_C,
                           m[7:0] & fic_pkg::AX_MASK, pwdata[7:0], aset, 8'h00);
            // these flags are never cleared by vectoring
            d.pflag = upd16(q.pflag, wr && paddr == fic_pkg::OFF_PERIPH_FLAG,
                            m[15:0], pwdata[15:0], fset);
        end

        // ======================================================
        // configuration writes
        if (wr) begin
            unique case (paddr)
                fic_pkg::OFF_ENABLE: begin
                    d.ena = (q.ena & ~m[13:0]) | (pwdata[13:0] & m[13:0]);
                    if (m[fic_pkg::EN_GLOBAL]) begin
                        d.ea = pwdata[fic_pkg::EN_GLOBAL];
                    end
                end
                fic_pkg::OFF_PRIO_LOW_A:  d.pl_a = (q.pl_a & ~m[6:0]) | (pwdata[6:0] & m[6:0]);
                fic_pkg::OFF_PRIO_HIGH_A: d.ph_a = (q.ph_a & ~m[6:0]) | (pwdata[6:0] & m[6:0]);
                fic_pkg::OFF_PRIO_LOW_B:  d.pl_b = (q.pl_b & ~m[6:0]) | (pwdata[6:0] & m[6:0]);
                fic_pkg::OFF_PRIO_HIGH_B: d.ph_b = (q.ph_b & ~m[6:0]) | (pwdata[6:0] & m[6:0]);
                default: ;
            endcase
        end

        // ======================================================
        // apb answer: one wait state, data prepared before pready
        d.pready  = rd_phase;
        d.pslverr = 1'b0;
        if (rd_phase) begin
            unique case (paddr)
                fic_pkg::OFF_ENABLE:      d.prdata = {q.ea, 17'h00000, q.ena};
                fic_pkg::OFF_PRIO_LOW_A:  d.prdata = {25'h0000000, q.pl_a};
                fic_pkg::OFF_PRIO_HIGH_A: d.prdata = {25'h0000000, q.ph_a};
                fic_pkg::OFF_PRIO_LOW_B:  d.prdata = {25'h0000000, q.pl_b};
                fic_pkg::OFF_PRIO_HIGH_B: d.prdata = {25'h0000000, q.ph_b};
                fic_pkg::OFF_TIMER_CTRL:  d.prdata = {24'h000000, q.timer_control_reg};
                fic_pkg::OFF_EXT_CTRL:    d.prdata = {24'h000000, q.xcon};
                fic_pkg::OFF_PERIPH_FLAG: d.prdata = {16'h0000, q.pflag};
                fic_pkg::OFF_POWER_CTRL:  d.prdata = {24'h000000, q.pcon};
                fic_pkg::OFF_AUX_C:       d.prdata = {24'h000000, q.aux};
                fic_pkg::OFF_STATUS:      d.prdata = {q.sample, 13'h0000, q.hold, q.in_srv};
                default: begin
                    d.prdata  = 32'h00000000;
                    d.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // a zero here would look like a held pin and set level flags after reset
            q       <= '0;
            q.sync1 <= fic_pkg::PIN_IDLE;
            q.sync2 <= fic_pkg::PIN_IDLE;
            q.prev  <= fic_pkg::PIN_IDLE;
        end else begin
            q <= d;
        end
    end

    assign pready    = q.pready;
    assign prdata    = q.prdata;
    assign pslverr   = q.pslverr;
    assign vec_valid = q.vec_valid;
    assign vec_addr  = q.vec_addr;
    assign vec_level = q.vec_level;

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_vec_final_cycle: assert property (vec_valid |-> $past(core_final_cycle))
        else $error("vector issued outside a final cycle");
    a_vec_after_hold: assert property (vec_valid |-> !$past(q.hold) && !$past(core_reti))
        else $error("vector issued while blocked");
    a_vec_addr_map: assert property (vec_valid |-> vec_addr[2:0] == 3'h3
                                      && vec_addr <= fic_pkg::VEC_LAST)
        else $error("vector address off the table");
    a_vec_global_en: assert property (vec_valid |-> $past(q.ea, 2))
        else $error("vector without global enable");
    a_vec_sampled: assert property (vec_valid |-> $past(q.sample) != 14'h0000)
        else $error("vector without a sampled request");
    a_no_preempt: assert property (vec_valid && $past(top[2]) |-> vec_level > $past(top[1:0]))
        else $error("equal or lower level preempted");
    a_srv_marked: assert property (vec_valid |-> q.in_srv[vec_level])
        else $error("level not marked in service");
    a_timer_clear: assert property (vec_valid
                                    && $past(arb.idx) == fic_pkg::SRC_TIMER_A
                                    |-> !q.timer_control_reg[fic_pkg::TC_TMR_A]
                                    || $past(evt.timer_a_rollover))
        else $error("timer flag kept after vectoring");
    a_level_track: assert property (!q.timer_control_reg[fic_pkg::TC_EXT0_TYP] && !act[0] ##1
                                    !q.timer_control_reg[fic_pkg::TC_EXT0_TYP] && !act[0]
                                    |=> !q.timer_control_reg[fic_pkg::TC_EXT0_FLG])
        else $error("level flag does not follow its pin");
    a_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing broken");

    c_vector_taken: cover property (vec_valid);
    c_nested: cover property (vec_valid && $past(top[2]));
    c_reti_then_vec: cover property (core_reti ##[1:20] vec_valid);
    c_edge_vector: cover property (q.timer_control_reg[fic_pkg::TC_EXT1_TYP] && vec_valid);

endmodule

/* test/fic_core_model.sv */
`timescale 1ns/1ps
// ==========================================================
// core model: ends instructions and returns five clocks after the latest vector
module fic_core_model (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pacing and vector handshake
    input  wire logic slow,
    input  wire logic vec_valid,
    output logic      core_final_cycle,
    output logic      core_reti
);
    logic [2:0] cnt_q;
    // slow pacing makes every other polling cycle a blocked one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 3'h0;
            core_final_cycle <= 1'b0;
            core_reti <= 1'b0;
        end else begin
            core_final_cycle <= slow ? ~core_final_cycle : 1'b1;
            core_reti <= (cnt_q == 3'h1);
            cnt_q <= vec_valid ? 3'h4 : ((cnt_q != 3'h0) ? cnt_q - 3'h1 : 3'h0);
        end
    end
endmodule

/* test/tb_fic_intc.sv */
`timescale 1ns/1ps
module tb_fic_intc;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, slow;
    logic               ext_irq_pin_a, ext_irq_pin_b, ext_irq_pin_c;
    logic               vec_valid, core_final_cycle, core_reti;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [3:0]         pstrb;
    logic [15:0]        vec_addr;
    logic [1:0]         vec_level;
    fic_pkg::fic_evt_t  evt;
    int                 bad_count, checked;
    // rows: event bit, source index, flag offset, flag bit; rows 0..1 clear on vectoring
    int rb[18] = '{24, 23, 22, 20, 18, 17, 16, 15, 14, 7, 6, 1, 21, 19, 13, 0, 5, 2};
    int ri[18] = '{1, 3, 4, 5, 7, 8, 11, 12, 13, 9, 10, 10, 4, 5, 9, 10, 10, 10};
    int ro[18] = '{20, 20, 28, 28, 28, 28, 28, 28, 28, 28, 32, 36, 28, 28, 28, 36, 32, 32};
    int rf[18] = '{5, 7, 0, 2, 4, 5, 6, 7, 8, 10, 0, 7, 1, 3, 9, 6, 2, 5};
    fic_intc i_fic_intc (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .ext_irq_pin_a, .ext_irq_pin_b, .ext_irq_pin_c, .evt,
        .core_final_cycle, .core_reti, .vec_valid, .vec_addr, .vec_level);
    fic_core_model i_fic_core_model (.pclk, .presetn, .slow, .vec_valid, .core_final_cycle,
        .core_reti);
    // ==========================================================
    // tasks
    task wrap_up;
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin bad_count++; wrap_up(); end
        rd = prdata;
        perr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task pulse(input logic [24:0] b);
        @(posedge pclk) evt <= fic_pkg::fic_evt_t'(b);
        @(posedge pclk) evt <= '0;
    endtask
    // waiting past the bound when a call is wanted ends the run early
    task vec(input logic [15:0] exp, input bit want);
        logic [15:0] g;
        g = 16'hffff;
        for (int n = 0; n < 40; n++) begin
            @(posedge pclk);
            if (vec_valid === 1'b1) begin g = vec_addr; break; end
        end
        cmp({16'h0, g}, want ? {16'h0, exp} : 32'h0000ffff);
        if (want && g === 16'hffff) wrap_up();
    endtask
    // ==========================================================
    // stimulus
    initial begin pclk = 1'b0; forever #50 pclk = ~pclk; end
    initial begin repeat (20000) @(posedge pclk); bad_count++; wrap_up(); end
    initial begin
        {presetn, psel, penable, pwrite, slow, paddr, pwdata, pstrb} = {5'h0, 44'h0, 4'hf};
        {ext_irq_pin_a, ext_irq_pin_b, ext_irq_pin_c, evt} = {3'h7, 25'h0};
        bad_count = 0;
        checked = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmp(32'(vec_valid), 32'h0);
        apb(1'b0, fic_pkg::OFF_ENABLE, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b1, fic_pkg::OFF_ENABLE, 32'h80003fff);
        for (int r = 0; r < 18; r++) begin
            slow <= r[0];
            pulse(25'h1 << rb[r]);
            vec(16'h0003 + 16'(8 * ri[r]), 1'b1);
            apb(1'b0, 12'(ro[r]), 32'h0);
            cmp(32'(rd[rf[r]]), 32'(r > 1));
            cmp(32'(rd[rf[r]]), 32'(r > 1));
            apb(1'b1, 12'(ro[r]), 32'h0);
        end
        // hand-written cases: global enable, levels, ties, pins, software set, bad address
        apb(1'b1, fic_pkg::OFF_ENABLE, 32'h00003fff);
        pulse(25'h1 << 18);
        vec(16'h0, 1'b0);
        apb(1'b1, fic_pkg::OFF_ENABLE, 32'h80003fff);
        vec(16'h003b, 1'b1);
        apb(1'b1, fic_pkg::OFF_PERIPH_FLAG, 32'h0);
        apb(1'b1, fic_pkg::OFF_PRIO_LOW_B, 32'h40);
        apb(1'b1, fic_pkg::OFF_PRIO_HIGH_B, 32'h40);
        pulse(25'h0044000);
        vec(16'h006b, 1'b1);
        cmp(32'(vec_level), 32'h3);
        apb(1'b1, fic_pkg::OFF_PERIPH_FLAG, 32'h10);
        vec(16'h003b, 1'b1);
        apb(1'b1, fic_pkg::OFF_PERIPH_FLAG, 32'h0);
        pulse(25'h1800000);
        vec(16'h000b, 1'b1);
        vec(16'h001b, 1'b1);
        ext_irq_pin_a <= 1'b0;
        vec(16'h0003, 1'b1);
        ext_irq_pin_a <= 1'b1;
        apb(1'b1, fic_pkg::OFF_TIMER_CTRL, 32'h4);
        ext_irq_pin_b <= 1'b0;
        vec(16'h0013, 1'b1);
        apb(1'b0, fic_pkg::OFF_TIMER_CTRL, 32'h0);
        cmp(rd, 32'h4);
        ext_irq_pin_b <= 1'b1;
        apb(1'b1, fic_pkg::OFF_TIMER_CTRL, 32'h0);
        apb(1'b1, fic_pkg::OFF_PERIPH_FLAG, 32'h100);
        vec(16'h006b, 1'b1);
        apb(1'b1, fic_pkg::OFF_PERIPH_FLAG, 32'h0);
        apb(1'b1, fic_pkg::OFF_ENABLE, 32'h80003fef);
        apb(1'b1, fic_pkg::OFF_AUX_C, 32'h1);
        pulse(25'h1 << 21);
        vec(16'h0053, 1'b1);
        apb(1'b1, fic_pkg::OFF_PERIPH_FLAG, 32'h0);
        presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        @(posedge pclk);
        cmp({29'h0, vec_valid, pready, pslverr}, 32'h0);
        apb(1'b0, fic_pkg::OFF_AUX_C, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        cmp({rd[31:1], perr}, 32'h1);
        wrap_up();
    end
endmodule
